//--- nvm_defines.svh
// Constants for the nonvolatile memory erase/write sequencer.
// Assumes a 10 MHz mclk and an APB register slave with 32-bit data.
// Summary of operation
// RL1: Start needs key 0x55 then 0xAA, then start bit set; otherwise refused.
// RL2: Software places two no-operations after setting the start bit.
// RL3: EEPROM supports single word and 16-word block erase and write.
// RL4: EEPROM spans 1 Kbyte, word addresses 0x7FFC00 to 0x7FFFFE.
// RL5: Target location comes from low plus upper address registers.
// RL6: Write lasts about 2 ms; completion is flagged, not assumed.
// RL7: Software erases words before a word write.
// RL8: Core keeps running during an EEPROM cycle; no stall.
// RL9: Software starts no new cycle until the current one ends.
// RL10: Reads during a cycle return undefined data.
// RL11: Start bit set by software only; cleared by hardware at cycle end.
// RL12: Write-permit is zero at power-up; only software changes it.
// RL13: Reset during a write sets interrupted-write flag; address kept.
// RL14: Cycle end clears start bit, sets done flag held until software clears.
// RL15: Clearing write-permit mid-cycle does not abort the cycle.
// RL16: Start needs write-permit set by an earlier write, not the same one.
// RL17: Software keeps write-permit clear except while updating.
// RL18: Software disables interrupts during unlock and start.
// RL19: Erase configurations 4045 block and 4044 word, launched by start bit.
// RL20: Word write: erase, latch by table write, configure, unlock, start, poll.
// RL21: Table read returns the EEPROM word at the addressed location.
// RL22: Start bit is bit 15 of the control register.
// RL23: Address registers capture table instruction address bits 15:0 and 23:16.
// RL24: Program flash cycles stall the processor until done.
// RL25: Any other write between unlock steps discards the unlock.
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH
`define OFS_CONTROL     12'h760
`define OFS_ADDR_LOW    12'h762
`define OFS_ADDR_UPPER  12'h764
`define OFS_KEY         12'h766
`define OFS_STATUS      12'h768
// Bus byte address is four times the register index
`define ADR_CONTROL     {`OFS_CONTROL, 2'b00}
`define ADR_ADDR_LOW    {`OFS_ADDR_LOW, 2'b00}
`define ADR_ADDR_UPPER  {`OFS_ADDR_UPPER, 2'b00}
`define ADR_KEY         {`OFS_KEY, 2'b00}
`define ADR_STATUS      {`OFS_STATUS, 2'b00}
`define BIT_START       15
`define BIT_PERMIT      14
`define BIT_INTERRUPTED 13
`define BIT_TERMINATE   8
`define BIT_DONE        0
`define CONTROL_RESET   16'h0000
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA
`define EE_BASE         24'h7FFC00
`define CYCLE_TIME_US   2000
`define CLOCK_MHZ       10
`define CYCLE_COUNT     (`CYCLE_TIME_US * `CLOCK_MHZ)
`define BLOCK_WORDS     16
`endif

//--- nvm_pkg.sv
// Types shared by the sequencer files.
// Assumes nvm_defines.svh is on the include path.
package nvm_pkg;
    typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_OPEN} unlock_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ERASE, SEQ_WRITE} seq_t;
    typedef logic [15:0] word_t;
endpackage : nvm_pkg

//--- ee_array.sv
// Data EEPROM array of 512 words with a write latch bank of 16 words.
// Assumes the sequencer drives one operation at a time.
`timescale 1ns/1ps
module ee_array (
    input  wire logic          mclk,
    input  wire logic          ce,
    input  wire logic [8:0]    rdAddr,
    output logic [15:0]        rdData,
    input  wire logic          latchWe,
    input  wire logic [3:0]    latchIdx,
    input  wire logic [15:0]   latchData,
    input  wire logic          opGo,
    input  wire logic          opErase,
    input  wire logic          opBlock,
    input  wire logic [8:0]    opAddr
);
    logic [15:0] mem [0:511];
    logic [15:0] latchBank [0:15];

    always_ff @(posedge mclk) begin
        if (ce) begin
            rdData <= mem[rdAddr];
            if (latchWe) latchBank[latchIdx] <= latchData;
            if (opGo) begin
                for (int k = 0; k < 16; k++) begin
                    if (opBlock || (opAddr[3:0] == 4'(k))) begin
                        mem[{opAddr[8:4], 4'(k)}] <= opErase ? 16'hFFFF : latchBank[k];
                    end
                end
            end
        end
    end
endmodule : ee_array

//--- nvm_sequencer.sv
// Erase/write sequencer for the data EEPROM with key unlock and APB registers.
// Assumes the core drives table accesses on tbl* ports and resets on mclk domain.
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_sequencer #(
    parameter int CYCLE_CYCLES = `CYCLE_COUNT
) (
    input  wire logic          mclk,
    input  wire logic          reset,
    input  wire logic          ce,
    input  wire logic          wdtOrMclrReset,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [13:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          tblValid,
    input  wire logic          tblWrite,
    input  wire logic [23:0]   tblAddr,
    input  wire logic [15:0]   tblWdata,
    output nvm_pkg::word_t     tblRdata,
    output logic               tblHit,
    output logic               cpuStall,
    output logic               nvmDoneFlag,
    output logic               busy
);
    import nvm_pkg::*;

    // ==================================================
    // Bus decode
    function automatic logic isEe(input logic [23:0] a);
        isEe = (a[23:10] == `EE_BASE >> 10);
    endfunction : isEe

    wire         wrAcc    = psel && penable && pwrite && ce;
    wire         rdAcc    = psel && penable && !pwrite;
    wire         hitCtl   = (paddr == `ADR_CONTROL);
    wire         hitLow   = (paddr == `ADR_ADDR_LOW);
    wire         hitUp    = (paddr == `ADR_ADDR_UPPER);
    wire         hitKey   = (paddr == `ADR_KEY);
    wire         hitSts   = (paddr == `ADR_STATUS);
    wire         mapped   = hitCtl | hitLow | hitUp | hitKey | hitSts;
    wire [15:0]  wd       = pwdata[15:0];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ==================================================
    // State
    logic        start_r, permit_r, interrupted_r, terminate_r, done_r;
    logic [5:0]  cfg_r;
    logic [15:0] addrLow_r;
    logic [7:0]  addrUp_r;
    unlock_t     unlock_r, unlock_nxt;
    seq_t        seq_r;
    logic [31:0] count_r;
    logic [31:0] prdata_r;
    logic        tblHit_r;

    // cfg: bit2 erase, bits3:0 op (5 block erase, A block write, others one word)
    wire opErase = cfg_r[2];
    wire opBlock = (cfg_r[3:0] == 4'h5) || (cfg_r[3:0] == 4'hA);

    // ==================================================
    // Unlock tracker
    wire keyFirst   = wrAcc && hitKey && (wd[7:0] == `KEY_FIRST);
    wire keySecond  = wrAcc && hitKey && (wd[7:0] == `KEY_SECOND);
    wire startReq   = wrAcc && hitCtl && wd[`BIT_START];          // see RL22
    wire launch     = startReq && (unlock_r == UNLOCK_OPEN) && permit_r
                      && !start_r;                                 // see RL1 see RL16

    always_comb begin
        unlock_nxt = unlock_r;
        if (wrAcc) begin
            unique case (unlock_r)
                UNLOCK_IDLE: unlock_nxt = keyFirst ? UNLOCK_HALF : UNLOCK_IDLE;
                UNLOCK_HALF: unlock_nxt = keySecond ? UNLOCK_OPEN :
                                          (keyFirst ? UNLOCK_HALF : UNLOCK_IDLE); // see RL25
                UNLOCK_OPEN: unlock_nxt = keyFirst ? UNLOCK_HALF : UNLOCK_IDLE;   // see RL25
            endcase
        end
    end

    // ==================================================
    // Cycle timing
    wire cycleEnd = (seq_r != SEQ_IDLE) && (count_r == 32'd0);    // see RL6

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            unlock_r <= UNLOCK_IDLE;
            seq_r    <= SEQ_IDLE;
            count_r  <= 32'd0;
        end else if (ce) begin
            unlock_r <= unlock_nxt;
            if (launch) begin
                seq_r   <= opErase ? SEQ_ERASE : SEQ_WRITE;         // see RL19
                count_r <= 32'(CYCLE_CYCLES - 1);
            end else if (cycleEnd) begin
                seq_r   <= SEQ_IDLE;
            end else if (seq_r != SEQ_IDLE) begin
                count_r <= count_r - 32'd1;
            end
        end
    end

    // ==================================================
    // Control register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            start_r     <= 1'b0;
            permit_r    <= 1'b0;                                    // see RL12
            terminate_r <= 1'b0;
            cfg_r       <= 6'h00;
            done_r      <= 1'b0;
        end else if (ce) begin
            if (launch) start_r <= 1'b1;                            // see RL11
            else if (cycleEnd) start_r <= 1'b0;                     // see RL14
            if (wrAcc && hitCtl) begin
                permit_r    <= wd[`BIT_PERMIT];                     // see RL15
                terminate_r <= wd[`BIT_TERMINATE];
                if (seq_r == SEQ_IDLE) cfg_r <= wd[5:0];
            end
            if (cycleEnd) done_r <= 1'b1;                           // see RL14
            else if (wrAcc && hitSts && wd[`BIT_DONE]) done_r <= 1'b0;
        end
    end

    // Interrupted flag survives this reset; set by master-clear or watchdog mid-cycle
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (wdtOrMclrReset && (seq_r != SEQ_IDLE)) interrupted_r <= 1'b1; // see RL13
            else if (wrAcc && hitCtl && !wd[`BIT_INTERRUPTED]) interrupted_r <= 1'b0;
            else if (interrupted_r !== 1'b1) interrupted_r <= 1'b0;
        end
    end

    // Address registers keep value across reset
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (tblValid) begin
                addrLow_r <= tblAddr[15:0];                         // see RL23
                addrUp_r  <= tblAddr[23:16];
            end else if (wrAcc && hitLow) addrLow_r <= wd;
            else if (wrAcc && hitUp) addrUp_r <= wd[7:0];
        end
    end

    // ==================================================
    // Array and table port
    wire [23:0] tgtAddr   = {addrUp_r, addrLow_r};                   // see RL5
    wire        tblEe     = tblValid && isEe(tblAddr);               // see RL4
    wire [8:0]  tblWord   = tblAddr[9:1];
    logic [15:0] arrData;

    ee_array u_array (
        .mclk      (mclk),
        .ce        (ce),
        .rdAddr    (tblWord),
        .rdData    (arrData),
        .latchWe   (tblEe && tblWrite),
        .latchIdx  (tblWord[3:0]),
        .latchData (tblWdata),
        .opGo      (cycleEnd && isEe(tgtAddr)),                     // see RL3
        .opErase   (seq_r == SEQ_ERASE),
        .opBlock   (opBlock),
        .opAddr    (tgtAddr[9:1])
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) tblHit_r <= 1'b0;
        else if (ce) tblHit_r <= tblEe && !tblWrite;
    end

    assign tblRdata = arrData;                                      // see RL21 see RL10
    assign tblHit   = tblHit_r;
    assign cpuStall = 1'b0;                                         // see RL8 see RL24
    assign busy     = start_r;
    assign nvmDoneFlag = done_r;

    // ==================================================
    // Read data
    wire [15:0] ctlRd = {start_r, permit_r, interrupted_r, 4'h0, terminate_r, 2'b00, cfg_r};
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) prdata_r <= 32'h0000_0000;
        else if (ce && psel && !penable && !pwrite) begin
            prdata_r <= hitCtl ? {16'h0000, ctlRd} :
                        hitLow ? {16'h0000, addrLow_r} :
                        hitUp  ? {24'h000000, addrUp_r} :
                        hitSts ? {31'h0, done_r} : 32'h0000_0000;
        end
    end
    assign prdata = rdAcc ? prdata_r : 32'h0000_0000;
endmodule : nvm_sequencer

//--- nvm_sequencer_properties.sv
// Port checker for the erase/write sequencer.
// Assumes one mclk domain and binding onto nvm_sequencer.
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_sequencer_properties #(parameter int CYCLE_CYCLES = 20) (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        wdtOrMclrReset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tblValid,
    input wire logic        tblWrite,
    input wire logic [23:0] tblAddr,
    input wire logic        tblHit,
    input wire logic        cpuStall,
    input wire logic        nvmDoneFlag,
    input wire logic        busy
);
    localparam int LO = CYCLE_CYCLES - 1;
    localparam int HI = CYCLE_CYCLES + 1;
    logic [21:0] w1_r, w2_r;
    logic        permit_r;
    int          len_r;
    wire take  = psel && penable && pwrite && pready;
    wire ctlWr = take && paddr == `ADR_CONTROL;
    wire inEe  = tblAddr >= `EE_BASE && tblAddr <= 24'h7FFFFF;
    wire keyOk = w2_r == {`ADR_KEY, `KEY_FIRST} && w1_r == {`ADR_KEY, `KEY_SECOND};
    wire goOk  = ctlWr && pwdata[15] && permit_r && keyOk;
    wire mapped = paddr inside {`ADR_CONTROL, `ADR_ADDR_LOW, `ADR_ADDR_UPPER,
                                `ADR_KEY, `ADR_STATUS};
    // Last two writes, permit level, busy length
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            w1_r     <= '0;
            w2_r     <= '0;
            permit_r <= 1'b0;
            len_r    <= 0;
        end else begin
            len_r <= busy ? len_r + 1 : 0;
            if (take) begin
                w1_r <= {paddr, pwdata[7:0]};
                w2_r <= w1_r;
            end
            if (ctlWr)
                permit_r <= pwdata[14];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence goReq;
        goOk && !busy;
    endsequence
    sequence runEnd;
        $fell(busy) && !wdtOrMclrReset && !$past(wdtOrMclrReset);
    endsequence
    // ==========================================
    // Properties
    AST_LAUNCH: assert property (goReq |=> busy)
        else $error("start not taken");
    AST_REFUSE: assert property ($rose(busy) |-> $past(goOk))
        else $error("start without unlock");
    AST_LENGTH: assert property (runEnd |-> len_r >= LO && len_r <= HI)
        else $error("cycle length off");
    AST_DONE: assert property (runEnd |-> ##[0:1] nvmDoneFlag)
        else $error("done flag not set");
    AST_HOLD: assert property (
        nvmDoneFlag && !(take && paddr == `ADR_STATUS && pwdata[0]) |=> nvmDoneFlag)
        else $error("done flag dropped");
    AST_HIT: assert property (tblValid && !tblWrite |=> tblHit == $past(inEe))
        else $error("table hit wrong");
    AST_NO_STALL: assert property (!cpuStall)
        else $error("core stalled");
    AST_APB: assert property (psel && penable |-> pready && pslverr == !mapped)
        else $error("apb answer wrong");
endmodule : nvm_sequencer_properties
bind nvm_sequencer nvm_sequencer_properties #(.CYCLE_CYCLES(CYCLE_CYCLES))
    nvm_sequencer_properties_inst (.mclk, .reset, .wdtOrMclrReset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .tblValid, .tblWrite, .tblAddr,
    .tblHit, .cpuStall, .nvmDoneFlag, .busy);

//--- core_model.sv
// Core model: APB register cycles and table accesses, called by the bench.
// Assumes the bench waits out each cycle before the next launch.
`timescale 1ns/1ps
`include "nvm_defines.svh"
module core_model (
    output logic                psel,
    output logic                penable,
    output logic                pwrite,
    output logic [13:0]         paddr,
    output logic [31:0]         pwdata,
    output logic                tblValid,
    output logic                tblWrite,
    output logic [23:0]         tblAddr,
    output nvm_pkg::word_t      tblWdata,
    input  wire logic           mclk,
    input  wire logic [31:0]    prdata,
    input  wire logic           pready,
    input  wire nvm_pkg::word_t tblRdata,
    input  wire logic           tblHit
);
    import nvm_pkg::*;
    logic [31:0] rdLast = '0;
    logic        hang = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    initial {tblValid, tblWrite, tblAddr, tblWdata} = '0;
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, 2'b00, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hang |= (pready !== 1'b1);
        rdLast = prdata;
        {psel, penable, paddr, pwdata} <= {1'b0, 1'b0, ~a, 2'b00, ~d};
    endtask : apb
    task automatic tbl(input logic wr, input logic [23:0] a, input word_t d);
        @(posedge mclk);
        {tblValid, tblWrite, tblAddr, tblWdata} <= {1'b1, wr, a, d};
        @(posedge mclk);
        {tblValid, tblAddr, tblWdata} <= {1'b0, ~a, ~d};
        @(posedge mclk);
        rdLast = {15'h0000, tblHit, tblRdata};
    endtask : tbl
    // Write config with permit, unlock with both keys, then start
    task automatic launch(input logic [15:0] cfg);
        apb(1'b1, `OFS_CONTROL, {16'h0000, cfg});
        apb(1'b1, `OFS_KEY, {24'h000000, `KEY_FIRST});
        apb(1'b1, `OFS_KEY, {24'h000000, `KEY_SECOND});
        apb(1'b1, `OFS_CONTROL, {16'h0000, cfg | 16'h8000});
        repeat (2) @(posedge mclk);
    endtask : launch
endmodule : core_model

//--- nvm_sequencer_tb.sv
// Self-checking bench for the sequencer with random data and corner cases.
// Assumes core_model and the checker are compiled before it.
`timescale 1ns/1ps
`include "nvm_defines.svh"
module nvm_sequencer_tb;
    import nvm_pkg::*;
    localparam int CYC = 20;
    logic mclk = 1'b0, reset = 1'b1, ce = 1'b1, wdtOrMclrReset = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, tblValid, tblWrite, tblHit;
    logic cpuStall, nvmDoneFlag, busy;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] tblAddr, a;
    word_t tblWdata, tblRdata, dat [16];
    int bad_count = 0, checks_done = 0;
    always #50 mclk = ~mclk;
    nvm_sequencer #(.CYCLE_CYCLES(CYC)) nvm_sequencer_inst (.mclk, .reset, .ce,
        .wdtOrMclrReset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tblValid, .tblWrite, .tblAddr, .tblWdata, .tblRdata, .tblHit,
        .cpuStall, .nvmDoneFlag, .busy);
    core_model core_model_inst (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .tblValid, .tblWrite, .tblAddr, .tblWdata, .tblRdata, .tblHit);
    function automatic logic [23:0] ee(input int i);
        return `EE_BASE + 24'(32 + 2 * i);
    endfunction : ee
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic w(input logic [11:0] ad, input logic [31:0] d);
        core_model_inst.apb(1'b1, ad, d);
        if (core_model_inst.hang) report_and_stop();
    endtask : w
    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        core_model_inst.apb(1'b0, ad, 32'h00000000);
        if (core_model_inst.hang) report_and_stop();
        chk(core_model_inst.rdLast, exp);
    endtask : rd
    task automatic report_and_stop();
        bad_count += core_model_inst.hang;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        bad_count += (n >= 200);
        if (n >= 200)
            report_and_stop();
        chk(nvmDoneFlag, 1'b1);
    endtask : waitIdle
    task automatic readBlock(input logic erased);
        for (int i = 0; i < 16; i++) begin
            a = ee(i);
            core_model_inst.tbl(1'b0, a, 16'h0000);
            chk(core_model_inst.rdLast, {15'h0000, 1'b1, erased ? 16'hFFFF : dat[i]});
        end
    endtask : readBlock
    initial begin
        void'($urandom(32'h387DE48D));
        foreach (dat[i]) dat[i] = word_t'($urandom);
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(`OFS_CONTROL, 32'h00000000);
        rd(`OFS_KEY, 32'h00000000);
        core_model_inst.apb(1'b0, 12'h770, 32'h00000000);
        chk(pslverr, 1'b1);
        w(`OFS_KEY, 32'h00000055);
        w(`OFS_KEY, 32'h000000AA);
        w(`OFS_CONTROL, 32'h0000C045);
        @(negedge mclk);
        chk(busy, 1'b0);
        w(`OFS_KEY, 32'h00000055);
        w(`OFS_STATUS, 32'h00000000);
        w(`OFS_KEY, 32'h000000AA);
        w(`OFS_CONTROL, 32'h0000C045);
        @(negedge mclk);
        chk(busy, 1'b0);
        core_model_inst.tbl(1'b0, 24'h000100, 16'h0000);
        chk(core_model_inst.rdLast, 32'h00000000 | core_model_inst.rdLast[15:0]);
        a = ee(0);
        core_model_inst.tbl(1'b0, a, 16'h0000);
        rd(`OFS_ADDR_LOW, {16'h0000, a[15:0]});
        rd(`OFS_ADDR_UPPER, {24'h000000, a[23:16]});
        core_model_inst.launch(16'h4045);
        w(`OFS_CONTROL, 32'h00000000);
        @(negedge mclk);
        chk({busy, cpuStall}, 2'b10);
        waitIdle();
        rd(`OFS_STATUS, 32'h00000001);
        w(`OFS_STATUS, 32'h00000001);
        @(negedge mclk);
        chk(nvmDoneFlag, 1'b0);
        readBlock(1'b1);
        for (int i = 0; i < 16; i++) core_model_inst.tbl(1'b1, ee(i), dat[i]);
        core_model_inst.launch(16'h400A);
        waitIdle();
        readBlock(1'b0);
        a = ee(3);
        w(`OFS_ADDR_LOW, {16'h0000, a[15:0]});
        w(`OFS_ADDR_UPPER, {24'h000000, a[23:16]});
        core_model_inst.launch(16'h4044);
        waitIdle();
        core_model_inst.tbl(1'b0, ee(3), 16'h0000);
        chk(core_model_inst.rdLast, 32'h0001FFFF);
        a = ee(4);
        core_model_inst.tbl(1'b0, a, 16'h0000);
        chk(core_model_inst.rdLast, {16'h0001, dat[4]});
        core_model_inst.launch(16'h4045);
        wdtOrMclrReset <= 1'b1;
        @(posedge mclk);
        {wdtOrMclrReset, reset} <= 2'b01;
        @(posedge mclk);
        reset <= 1'b0;
        rd(`OFS_CONTROL, 32'h00002000);
        rd(`OFS_ADDR_LOW, {16'h0000, a[15:0]});
        w(`OFS_CONTROL, 32'h00000000);
        rd(`OFS_CONTROL, 32'h00000000);
        ce <= 1'b0;
        w(`OFS_ADDR_LOW, 32'h00001234);
        ce <= 1'b1;
        rd(`OFS_ADDR_LOW, {16'h0000, a[15:0]});
        report_and_stop();
    end
endmodule : nvm_sequencer_tb
